/* File: verif/tb_top.sv */
/*
  Self-checking bench for the channel event status block: register
  reset values, control enables, sticky flags, interrupt and config load.
  Assumes the design package and module are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import rces_pkg::*;
  // ==========================================================================
  // Stimulus signals and design.
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  rces_bus_req_t bus_req = '0;
  logic [7:0] reg_rdata;
  logic sd = 1'b0, lock = 1'b0, emr = 1'b0, adapt = 1'b0, ev = 1'b0;
  logic [3:0] h = 4'h0, v = 4'h0;
  logic cfg_load = 1'b0;
  logic ce = 1'b1;
  logic [1:0] cfg_ev = 2'h0;
  logic irq, chk_en, gen_en;
  int n_errors = 0;
  int samples_checked = 0;

  always #2 mclk = ~mclk;

  rces_event_status u_rces_event_status (.mclk(mclk), .rstn(rstn), .ce(ce),
    .bus_req(bus_req), .reg_rdata(reg_rdata), .signal_detect_state(sd),
    .clock_recovery_locked(lock), .eye_measure_request(emr), .adapt_active(adapt),
    .eye_valid(ev), .horizontal_eye_opening(h), .vertical_eye_opening(v),
    .cfg_load(cfg_load), .cfg_event_enables(cfg_ev), .irq(irq),
    .pattern_checker_enable(chk_en), .pattern_generator_enable(gen_en));

  // ==========================================================================
  // Tasks.
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus_req <= '0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    bus_req <= '0;
    @(posedge mclk);
    chk($sformatf("reg %h", a), reg_rdata, exp);
  endtask

  task automatic eye(input logic [3:0] hh, input logic [3:0] vv);
    @(posedge mclk);
    ev <= 1'b1;
    h <= hh;
    v <= vv;
    @(posedge mclk);
    ev <= 1'b0;
  endtask

  task automatic test_done;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Watchdog.
  initial begin
    tick(5000);
    n_errors++;
    test_done();
  end

  // ==========================================================================
  // Tests.
  initial begin
    tick(20);
    rstn <= 1'b1;
    tick(1);
    rdc(ADDR_EYE_THR, 8'h21);
    rdc(ADDR_CTRL, 8'h10);
    rdc(ADDR_SPARE, 8'h00);
    rdc(ADDR_EYE_EN, 8'h00);
    rdc(ADDR_STATUS, 8'h00);
    rdc(ADDR_IRQ_STAT, 8'h00);
    rdc(ADDR_IRQ_MASK, 8'h00);
    rdc(8'h55, 8'h00);
    chk("enables", {6'h0, chk_en, gen_en}, 8'h00);
    wr(ADDR_CTRL, 8'h70);
    tick(1);
    chk("enables", {6'h0, chk_en, gen_en}, 8'h03);
    wr(ADDR_CTRL, 8'h13);
    tick(1);
    chk("enables", {6'h0, chk_en, gen_en}, 8'h00);
    wr(ADDR_STATUS, 8'hFF);
    rdc(ADDR_STATUS, 8'h00);
    sd <= 1'b1;
    lock <= 1'b1;
    tick(6);
    rdc(ADDR_STATUS, 8'h3C);
    rdc(ADDR_STATUS, 8'h30);
    sd <= 1'b0;
    tick(4);
    rdc(ADDR_STATUS, 8'h14);
    lock <= 1'b0;
    wr(ADDR_CTRL, 8'h10);
    lock <= 1'b1;
    sd <= 1'b1;
    tick(4);
    rdc(ADDR_STATUS, 8'h30);
    emr <= 1'b1;
    adapt <= 1'b1;
    tick(3);
    rdc(ADDR_STATUS, 8'h32);
    adapt <= 1'b0;
    tick(3);
    rdc(ADDR_STATUS, 8'h30);
    emr <= 1'b0;
    wr(ADDR_EYE_EN, 8'h40);
    eye(4'h0, 4'h5);
    tick(2);
    rdc(ADDR_STATUS, 8'h31);
    eye(4'h1, 4'h1);
    tick(2);
    rdc(ADDR_STATUS, 8'h31);
    eye(4'h1, 4'h2);
    tick(2);
    rdc(ADDR_STATUS, 8'h30);
    wr(ADDR_EYE_EN, 8'h00);
    eye(4'h0, 4'h0);
    tick(2);
    rdc(ADDR_STATUS, 8'h30);
    rdc(ADDR_IRQ_STAT, 8'h07);
    chk("irq", {7'h0, irq}, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h01);
    tick(2);
    chk("irq", {7'h0, irq}, 8'h01);
    wr(ADDR_IRQ_STAT, 8'h01);
    tick(2);
    chk("irq", {7'h0, irq}, 8'h00);
    rdc(ADDR_IRQ_STAT, 8'h06);
    cfg_ev <= 2'h3;
    cfg_load <= 1'b1;
    tick(1);
    cfg_load <= 1'b0;
    rdc(ADDR_CTRL, 8'h13);
    ce <= 1'b0;
    wr(ADDR_CTRL, 8'h70);
    ce <= 1'b1;
    tick(1);
    chk("frozen enables", {6'h0, chk_en, gen_en}, 8'h00);
    rdc(ADDR_CTRL, 8'h13);
    test_done();
  end
endmodule // tb_top

`default_nettype wire

/* File: verilog/rces_event_status.sv */
/*
  Channel event status and control registers of a serial retimer channel,
  with sticky clear-on-read event flags and a masked interrupt.
  Assumes all inputs are synchronous to mclk and a one-cycle register port.
*/
`timescale 1ns/100ps
`default_nettype none

module rces_event_status
  import rces_pkg::*;
#(
  parameter int EYE_W = 4
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire rces_bus_req_t bus_req,
  output logic [7:0] reg_rdata,
  input wire logic signal_detect_state,
  input wire logic clock_recovery_locked,
  input wire logic eye_measure_request,
  input wire logic adapt_active,
  input wire logic eye_valid,
  input wire logic [EYE_W-1:0] horizontal_eye_opening,
  input wire logic [EYE_W-1:0] vertical_eye_opening,
  input wire logic cfg_load,
  input wire logic [1:0] cfg_event_enables,
  output logic irq,
  output logic pattern_checker_enable,
  output logic pattern_generator_enable
);

  // ==========================================================================
  // State and event detection.
  rces_state_t st_r;
  rces_state_t st_nxt;
  logic [2:0] ev;
  logic [2:0] raw_ev;
  logic [2:0] ev_en;
  logic wr_hit_ctrl;
  logic rd_status;
  logic [EYE_W-1:0] thr_h;
  logic [EYE_W-1:0] thr_v;

  assign thr_h = EYE_W'(st_r.eye_thr[3:0]);
  assign thr_v = EYE_W'(st_r.eye_thr[7:4]);
  assign rd_status = bus_req.rd && (bus_req.addr == ADDR_STATUS);
  assign wr_hit_ctrl = bus_req.wr && (bus_req.addr == ADDR_CTRL);

  assign raw_ev[EV_LOCK_GAIN] = clock_recovery_locked && !st_r.lock_q;
  assign raw_ev[EV_SD_CHANGE] = signal_detect_state ^ st_r.sd_q;
  assign raw_ev[EV_EYE_LOW] = eye_valid && st_r.lock_q &&
                              ((horizontal_eye_opening < thr_h) || (vertical_eye_opening < thr_v));
  assign ev_en[EV_LOCK_GAIN] = st_r.ctrl[CTRL_LOCK_FLAG_EN];
  assign ev_en[EV_SD_CHANGE] = st_r.ctrl[CTRL_SD_FLAG_EN];
  assign ev_en[EV_EYE_LOW] = st_r.eye_en;

  // Each event lane is gated by its own enable.
  for (genvar gi = 0; gi < $bits(ev); gi++) begin : g_event
    assign ev[gi] = raw_ev[gi] && ev_en[gi];
  end

  // ==========================================================================
  // Next state.
  always_comb begin
    st_nxt = st_r;
    if (ce) begin
      st_nxt.sd_q = signal_detect_state;
      st_nxt.lock_q = clock_recovery_locked;
      st_nxt.range_err = eye_measure_request && adapt_active;
      st_nxt.flags = (st_r.flags & ~(rd_status ? 3'h7 : 3'h0)) | ev;
      st_nxt.irq_stat = st_r.irq_stat | ev;
      st_nxt.rdata = 8'h00;
      if (bus_req.wr) begin
        case (bus_req.addr)
          ADDR_EYE_THR: st_nxt.eye_thr = bus_req.wdata;
          ADDR_CTRL: st_nxt.ctrl = bus_req.wdata;
          ADDR_SPARE: st_nxt.spare = bus_req.wdata;
          ADDR_EYE_EN: st_nxt.eye_en = bus_req.wdata[EYE_EN_BIT];
          ADDR_IRQ_STAT: st_nxt.irq_stat = (st_r.irq_stat & ~bus_req.wdata[2:0]) | ev;
          ADDR_IRQ_MASK: st_nxt.irq_mask = bus_req.wdata[2:0];
          default: st_nxt.spare = st_r.spare;
        endcase
      end
      if (cfg_load) begin
        st_nxt.ctrl[CTRL_LOCK_FLAG_EN] = cfg_event_enables[1];
        st_nxt.ctrl[CTRL_SD_FLAG_EN] = cfg_event_enables[0];
      end
      if (bus_req.rd) begin
        case (bus_req.addr)
          ADDR_EYE_THR: st_nxt.rdata = st_r.eye_thr;
          ADDR_STATUS: st_nxt.rdata = {2'b00, st_r.sd_q, st_r.lock_q, st_r.flags[EV_LOCK_GAIN],
                                       st_r.flags[EV_SD_CHANGE], st_r.range_err,
                                       st_r.flags[EV_EYE_LOW]};
          ADDR_CTRL: st_nxt.rdata = st_r.ctrl;
          ADDR_SPARE: st_nxt.rdata = st_r.spare;
          ADDR_EYE_EN: st_nxt.rdata = 8'(st_r.eye_en) << EYE_EN_BIT;
          ADDR_IRQ_STAT: st_nxt.rdata = {5'h00, st_r.irq_stat};
          ADDR_IRQ_MASK: st_nxt.rdata = {5'h00, st_r.irq_mask};
          default: st_nxt.rdata = 8'h00;
        endcase
      end
      st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
    end
  end

  // ==========================================================================
  // State register.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_r <= '0;
      st_r.eye_thr <= EYE_THR_RST;
      st_r.ctrl <= CTRL_RST;
      st_r.spare <= SPARE_RST;
      st_r.eye_en <= EYE_EN_RST;
      st_r.irq_mask <= IRQ_MASK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign irq = st_r.irq;
  assign pattern_checker_enable = st_r.ctrl[CTRL_CHK_EN];
  assign pattern_generator_enable = st_r.ctrl[CTRL_GEN_EN];

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_status_read;
    ce && rd_status;
  endsequence

  sequence s_lock_rise;
    ce && clock_recovery_locked && !st_r.lock_q;
  endsequence

  a_reset_values: assert property (!$past(rstn) |-> st_r.ctrl == CTRL_RST && st_r.eye_thr == EYE_THR_RST)
    else $error("Control or threshold reset value wrong.");
  a_lock_gain_set: assert property (s_lock_rise ##0 st_r.ctrl[CTRL_LOCK_FLAG_EN] |=> st_r.flags[EV_LOCK_GAIN])
    else $error("Lock gain flag not set on lock rise.");
  a_lock_gain_gated: assert property (ce && !st_r.ctrl[CTRL_LOCK_FLAG_EN] && !st_r.flags[EV_LOCK_GAIN]
    |=> !st_r.flags[EV_LOCK_GAIN])
    else $error("Lock gain flag set while disabled.");
  a_sd_change_set: assert property (ce && st_r.ctrl[CTRL_SD_FLAG_EN] && (signal_detect_state != st_r.sd_q)
    |=> st_r.flags[EV_SD_CHANGE])
    else $error("Detect change flag not set.");
  a_sd_change_gated: assert property (ce && !st_r.ctrl[CTRL_SD_FLAG_EN] && !st_r.flags[EV_SD_CHANGE]
    |=> !st_r.flags[EV_SD_CHANGE])
    else $error("Detect change flag set while disabled.");
  a_flag_sticky: assert property (ce && !rd_status && st_r.flags[EV_LOCK_GAIN] |=> st_r.flags[EV_LOCK_GAIN])
    else $error("Event flag dropped without a read.");
  a_read_clears: assert property (s_status_read ##0 (ev == 3'h0) |=> st_r.flags == 3'h0)
    else $error("Status read did not clear flags.");
  a_read_value: assert property (s_status_read ##0 st_r.flags[EV_LOCK_GAIN] |=> reg_rdata[STAT_LOCK_GAIN])
    else $error("Flag lost before being read.");
  a_live_bits: assert property (s_status_read |=> reg_rdata[STAT_SD_STATE] == $past(signal_detect_state, 2) &&
    reg_rdata[7:6] == 2'b00)
    else $error("Status live bits or upper bits wrong.");
  a_lock_bit: assert property (s_status_read |=> reg_rdata[STAT_LOCKED] == $past(clock_recovery_locked, 2))
    else $error("Lock status bit wrong.");
  a_range_error: assert property (ce |=> st_r.range_err == $past(eye_measure_request && adapt_active))
    else $error("Range error does not follow its cause.");
  a_eye_low_set: assert property (ce && eye_valid && st_r.lock_q && st_r.eye_en &&
    (horizontal_eye_opening < thr_h) |=> st_r.flags[EV_EYE_LOW])
    else $error("Eye low flag not set.");
  a_eye_low_gated: assert property (ce && !st_r.eye_en && !st_r.flags[EV_EYE_LOW] |=> !st_r.flags[EV_EYE_LOW])
    else $error("Eye low flag set while disabled.");
  a_enable_write: assert property (ce && wr_hit_ctrl |=> pattern_checker_enable == $past(bus_req.wdata[CTRL_CHK_EN]) &&
    pattern_generator_enable == $past(bus_req.wdata[CTRL_GEN_EN]))
    else $error("Pattern enables do not follow write.");
  a_cfg_load: assert property (ce && cfg_load |=> st_r.ctrl[1:0] == $past(cfg_event_enables))
    else $error("Configuration load of event enables failed.");

  // ==========================================================================
  // Sequences for the event and register checks.
  sequence s_sd_edge;
    ce && (signal_detect_state != st_r.sd_q);
  endsequence

  sequence s_eye_armed;
    ce && eye_valid && st_r.lock_q && st_r.eye_en;
  endsequence

  sequence s_ctrl_write;
    ce && wr_hit_ctrl && !cfg_load;
  endsequence

  sequence s_status_write;
    ce && bus_req.wr && (bus_req.addr == ADDR_STATUS);
  endsequence

  // ==========================================================================
  // Live status bits.
  a_sd_tracks: assert property (ce |=> st_r.sd_q == $past(signal_detect_state))
    else $error("Signal detect status does not track its input.");

  a_lock_tracks: assert property (ce |=> st_r.lock_q == $past(clock_recovery_locked))
    else $error("Lock status does not track its input.");

  a_range_needs_adapt: assert property (ce && !adapt_active |=> !st_r.range_err)
    else $error("Range error raised outside adaptation.");

  a_range_needs_request: assert property (ce && !eye_measure_request |=> !st_r.range_err)
    else $error("Range error raised without a measure request.");

  a_range_raised: assert property (ce && eye_measure_request && adapt_active |=> st_r.range_err)
    else $error("Range error not raised.");

  // ==========================================================================
  // Event flags.
  a_sd_rise_set: assert property (s_sd_edge ##0 (signal_detect_state && ev_en[EV_SD_CHANGE])
    |=> st_r.flags[EV_SD_CHANGE])
    else $error("Detect change flag not set on rise.");

  a_sd_fall_set: assert property (s_sd_edge ##0 (!signal_detect_state && ev_en[EV_SD_CHANGE])
    |=> st_r.flags[EV_SD_CHANGE])
    else $error("Detect change flag not set on fall.");

  a_sd_steady_quiet: assert property (ce && (signal_detect_state == st_r.sd_q) &&
    !st_r.flags[EV_SD_CHANGE] |=> !st_r.flags[EV_SD_CHANGE])
    else $error("Detect change flag set without an edge.");

  a_lock_fall_quiet: assert property (ce && !clock_recovery_locked && !st_r.flags[EV_LOCK_GAIN]
    |=> !st_r.flags[EV_LOCK_GAIN])
    else $error("Lock gain flag set while unlocked.");

  a_lock_steady_quiet: assert property (ce && st_r.lock_q && !st_r.flags[EV_LOCK_GAIN]
    |=> !st_r.flags[EV_LOCK_GAIN])
    else $error("Lock gain flag set without a rise.");

  a_eye_vert_set: assert property (s_eye_armed ##0 (vertical_eye_opening < thr_v)
    |=> st_r.flags[EV_EYE_LOW])
    else $error("Eye low flag not set on vertical opening.");

  a_eye_any_set: assert property (s_eye_armed ##0
    ((horizontal_eye_opening < thr_h) || (vertical_eye_opening < thr_v)) |=> st_r.flags[EV_EYE_LOW])
    else $error("Eye low flag not set below thresholds.");

  a_eye_needs_lock: assert property (ce && !st_r.lock_q && !st_r.flags[EV_EYE_LOW]
    |=> !st_r.flags[EV_EYE_LOW])
    else $error("Eye low flag set before lock.");

  a_eye_needs_valid: assert property (ce && !eye_valid && !st_r.flags[EV_EYE_LOW]
    |=> !st_r.flags[EV_EYE_LOW])
    else $error("Eye low flag set without a measurement.");

  a_eye_above_quiet: assert property (ce && (horizontal_eye_opening >= thr_h) &&
    (vertical_eye_opening >= thr_v) && !st_r.flags[EV_EYE_LOW] |=> !st_r.flags[EV_EYE_LOW])
    else $error("Eye low flag set above thresholds.");

  // ==========================================================================
  // Register port.
  a_ctrl_write: assert property (s_ctrl_write |=> st_r.ctrl == $past(bus_req.wdata))
    else $error("Control register write lost.");

  a_ctrl_read: assert property (ce && bus_req.rd && (bus_req.addr == ADDR_CTRL)
    |=> reg_rdata == $past(st_r.ctrl))
    else $error("Control register read wrong.");

  a_thr_write: assert property (ce && bus_req.wr && (bus_req.addr == ADDR_EYE_THR)
    |=> st_r.eye_thr == $past(bus_req.wdata))
    else $error("Threshold register write lost.");

  a_thr_read: assert property (ce && bus_req.rd && (bus_req.addr == ADDR_EYE_THR)
    |=> reg_rdata == $past(st_r.eye_thr))
    else $error("Threshold register read wrong.");

  a_eye_en_write: assert property (ce && bus_req.wr && (bus_req.addr == ADDR_EYE_EN)
    |=> st_r.eye_en == $past(bus_req.wdata[EYE_EN_BIT]))
    else $error("Eye flag enable write lost.");

  a_spare_write: assert property (ce && bus_req.wr && (bus_req.addr == ADDR_SPARE)
    |=> st_r.spare == $past(bus_req.wdata))
    else $error("Spare register write lost.");

  a_spare_read: assert property (ce && bus_req.rd && (bus_req.addr == ADDR_SPARE)
    |=> reg_rdata == $past(st_r.spare))
    else $error("Spare register read wrong.");

  a_status_wr_ignored: assert property (s_status_write
    |=> st_r.flags == ($past(st_r.flags) | $past(ev)))
    else $error("Status write changed the flags.");

  a_rdata_idle: assert property (ce && !bus_req.rd |=> reg_rdata == 8'h00)
    else $error("Read data not zero outside a read.");

  a_read_snapshot: assert property (s_status_read |=>
    reg_rdata[STAT_SD_CHANGE] == $past(st_r.flags[EV_SD_CHANGE]) &&
    reg_rdata[STAT_EYE_LOW] == $past(st_r.flags[EV_EYE_LOW]) &&
    reg_rdata[STAT_RANGE_ERR] == $past(st_r.range_err))
    else $error("Status read snapshot wrong.");

  a_enables_reset: assert property (!$past(rstn) |->
    !pattern_checker_enable && !pattern_generator_enable)
    else $error("Pattern enables not zero after reset.");

  a_event_en_reset: assert property (!$past(rstn) |->
    !st_r.ctrl[CTRL_LOCK_FLAG_EN] && !st_r.ctrl[CTRL_SD_FLAG_EN])
    else $error("Event flag enables not zero after reset.");

  a_irq_mask_write: assert property (ce && bus_req.wr && (bus_req.addr == ADDR_IRQ_MASK)
    |=> st_r.irq_mask == $past(bus_req.wdata[2:0]))
    else $error("Interrupt mask write lost.");

  a_irq_mask_read: assert property (ce && bus_req.rd && (bus_req.addr == ADDR_IRQ_MASK)
    |=> reg_rdata == {5'h00, $past(st_r.irq_mask)})
    else $error("Interrupt mask read wrong.");

  // ==========================================================================
  // Per-event flag and interrupt status checks.
  for (genvar gj = 0; gj < $bits(ev); gj++) begin : g_event_chk
    a_flag_hold: assert property (ce && !rd_status && st_r.flags[gj] |=> st_r.flags[gj])
      else $error("Event flag dropped without a read.");

    a_flag_set_wins: assert property (s_status_read ##0 ev[gj] |=> st_r.flags[gj])
      else $error("Event lost against a status read.");

    a_flag_gated: assert property (ce && !ev_en[gj] && !st_r.flags[gj] |=> !st_r.flags[gj])
      else $error("Event flag set while its enable is low.");

    a_irq_stat_set: assert property (ce && ev[gj] |=> st_r.irq_stat[gj])
      else $error("Interrupt status not set by event.");

    a_irq_stat_hold: assert property (ce && st_r.irq_stat[gj] &&
      !(bus_req.wr && (bus_req.addr == ADDR_IRQ_STAT) && bus_req.wdata[gj]) |=> st_r.irq_stat[gj])
      else $error("Interrupt status dropped without a clear.");
  end

  // ==========================================================================
  // Interrupt output and clock enable.
  a_irq_level: assert property (irq == |(st_r.irq_stat & st_r.irq_mask))
    else $error("Interrupt output does not match masked status.");

  a_irq_clear: assert property (ce && bus_req.wr && (bus_req.addr == ADDR_IRQ_STAT) &&
    bus_req.wdata[EV_EYE_LOW] && !ev[EV_EYE_LOW] |=> !st_r.irq_stat[EV_EYE_LOW])
    else $error("Interrupt status not cleared by write.");

  a_freeze: assert property (!ce |=> st_r == $past(st_r))
    else $error("State changed while clock enable low.");

endmodule // rces_event_status

`default_nettype wire

/* File: verilog/rces_pkg.sv */
/*
  Package for the retimer channel event status block: register offsets,
  field positions, reset values and the structs that carry the register
  port and the block state.
  Assumes the register port is 8 bits wide and byte-addressed.
*/
`default_nettype none

package rces_pkg;

  // ==========================================================================
  // Register offsets.
  localparam logic [7:0] ADDR_EYE_EN = 8'h36;
  localparam logic [7:0] ADDR_EYE_THR = 8'h76;
  localparam logic [7:0] ADDR_STATUS = 8'h78;
  localparam logic [7:0] ADDR_CTRL = 8'h79;
  localparam logic [7:0] ADDR_SPARE = 8'h7A;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h80;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h81;

  // ==========================================================================
  // Field positions.
  localparam int STAT_SD_STATE = 5;
  localparam int STAT_LOCKED = 4;
  localparam int STAT_LOCK_GAIN = 3;
  localparam int STAT_SD_CHANGE = 2;
  localparam int STAT_RANGE_ERR = 1;
  localparam int STAT_EYE_LOW = 0;
  localparam int CTRL_CHK_EN = 6;
  localparam int CTRL_GEN_EN = 5;
  localparam int CTRL_LOCK_FLAG_EN = 1;
  localparam int CTRL_SD_FLAG_EN = 0;
  localparam int EYE_EN_BIT = 6;
  localparam int EV_LOCK_GAIN = 2;
  localparam int EV_SD_CHANGE = 1;
  localparam int EV_EYE_LOW = 0;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0] EYE_THR_RST = 8'h21;
  localparam logic [7:0] CTRL_RST = 8'h10;
  localparam logic [7:0] SPARE_RST = 8'h00;
  localparam logic EYE_EN_RST = 1'b0;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // ==========================================================================
  // Carriers.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rces_bus_req_t;

  typedef struct packed {
    logic [7:0] eye_thr;
    logic [7:0] ctrl;
    logic [7:0] spare;
    logic eye_en;
    logic sd_q;
    logic lock_q;
    logic range_err;
    logic [2:0] flags;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [7:0] rdata;
    logic irq;
  } rces_state_t;

endpackage

`default_nettype wire
